// ==== verilog/iec_pkg.sv ====
// Constants and types for the interrupt and event controller.
// Assumes one APB slave port with a 12-bit byte address.
package iec_pkg;
  localparam int NODES = 96;
  localparam int CHANS = 8;
  localparam int TRAPS = 8;
  localparam int SHARED_BASE = 88;
  // Register byte offsets
  localparam logic [11:0] OFF_NODE = 12'h000;
  localparam logic [11:0] OFF_CHAN = 12'h200;
  localparam logic [11:0] OFF_EDGE = 12'h300;
  localparam logic [11:0] OFF_ROUTE = 12'h304;
  localparam logic [11:0] OFF_PAT = 12'h308;
  localparam logic [11:0] OFF_SEL = 12'h30c;
  localparam logic [11:0] OFF_TRAP = 12'h310;
  localparam logic [11:0] OFF_CFG = 12'h314;
  localparam logic [11:0] OFF_STAT = 12'h318;
  // Node control fields
  localparam int NODE_EN_BIT = 6;
  localparam int NODE_FLAG_BIT = 7;
  localparam int NODE_XFER_BIT = 8;
  localparam int NODE_CH_LSB = 9;
  // Channel control fields
  localparam int CTL_INC_SRC = 0;
  localparam int CTL_INC_DST = 1;
  localparam int CTL_WORD = 2;
  localparam int CTL_CONT = 3;
  // Latency in clocks
  localparam logic [3:0] LAT_JC = 4'h7;
  localparam logic [3:0] LAT_NOJC = 4'hb;
  // Vector numbering: traps first, then nodes
  localparam logic [7:0] TRAP_VEC_BASE = 8'h00;
  localparam logic [7:0] NODE_VEC_BASE = 8'h08;
  localparam int TRAP_SR0 = 6;
  localparam int TRAP_SR1 = 7;
  localparam logic [3:0] RST_ZERO4 = 4'h0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SVC = 2'b10
  } svc_state_t;
endpackage

// ==== verilog/irq_event_ctrl.sv ====
// Interrupt nodes, event transfer channels, edge router and trap logic.
// Assumes an APB master on the register port and a CPU that acknowledges
// a vectored service, reports trap return and accepts a one-cycle transfer.
module irq_event_ctrl (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [95:0] src_req,
  input wire logic [7:0] alt_req,
  input wire logic [3:0] ext_in,
  input wire logic [5:0] trap_in,
  input wire logic [2:0] ext_service_pins,
  input wire logic swtrap_valid,
  input wire logic [7:0] swtrap_num,
  input wire logic cpu_ack,
  input wire logic cpu_ret,
  output logic irq_req,
  output logic [7:0] irq_vector,
  output logic irq_is_trap,
  output logic xfer_valid,
  output logic [15:0] xfer_src,
  output logic [15:0] xfer_dst,
  output logic xfer_word
);
  typedef struct packed {
    logic [95:0] flag;
    logic [95:0] en;
    logic [95:0] xfer;
    logic [95:0][3:0] prio;
    logic [95:0][2:0] chan;
    logic [7:0][15:0] src;
    logic [7:0][15:0] dst;
    logic [7:0][7:0] cnt;
    logic [7:0][3:0] ctl;
    logic [7:0] edge_mode;
    logic [15:0] route;
    logic [3:0] miss;
    logic [31:0] pat;
    logic [7:0] sel;
    logic [7:0] tflag;
    logic [7:0] tpend;
    logic [3:0] tlvl;
    logic jc;
    logic [3:0] ext_prev;
    logic [2:0] esr_prev;
    iec_pkg::svc_state_t st;
    logic [3:0] lat;
    logic irq_req;
    logic [7:0] vec;
    logic is_trap;
    logic xv;
    logic [15:0] xs;
    logic [15:0] xd;
    logic xw;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t q;
  state_t n;
  logic take_svc;
  logic take_trap;
  logic take_xfer;
  logic [2:0] xch;
  logic [6:0] bidx;

  // Two-bit edge select: bit 0 rising, bit 1 falling
  function automatic logic edge_hit(input logic [1:0] m, input logic cur,
                                    input logic prev);
    edge_hit = (m[0] && cur && !prev) || (m[1] && !cur && prev);
  endfunction

  // Next state: bus, event sources, arbitration and service sequencing
  always_comb begin
    logic [6:0] nidx;
    logic [2:0] cidx;
    logic node_hit;
    logic ch_hit;
    logic hit;
    logic [31:0] rd;
    logic [95:0] req;
    logic [3:0] ev;
    logic [3:0] gate;
    logic [7:0] tev;
    logic [7:0] snum;
    logic best_found;
    logic [3:0] best_prio;
    logic tp_found;
    logic [2:0] tidx;
    logic [2:0] ch;
    logic [15:0] step;
    nidx = paddr[8:2];
    cidx = paddr[6:4];
    node_hit = 1'b0;
    ch_hit = 1'b0;
    hit = 1'b1;
    rd = 32'h0000_0000;
    req = src_req;
    ev = 4'h0;
    gate = 4'h0;
    tev = 8'h00;
    snum = 8'h00;
    best_found = 1'b0;
    best_prio = 4'h0;
    tp_found = 1'b0;
    tidx = 3'h0;
    ch = 3'h0;
    step = 16'h0000;
    take_svc = 1'b0;
    take_trap = 1'b0;
    take_xfer = 1'b0;
    xch = 3'h0;
    bidx = 7'h00;
    n = q;
    n.xv = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;

    // Register read decode
    node_hit = (paddr[11:9] == 3'h0) && (nidx < 7'd96);
    ch_hit = (paddr[11:8] == iec_pkg::OFF_CHAN[11:8]) && !paddr[7];
    if (node_hit) begin
      rd = {20'h00000, q.chan[nidx], q.xfer[nidx], q.flag[nidx],
            q.en[nidx], 2'b00, q.prio[nidx]};
    end else if (ch_hit) begin
      case (paddr[3:2])
        2'h0: rd = {16'h0000, q.src[cidx]};
        2'h1: rd = {16'h0000, q.dst[cidx]};
        2'h2: rd = {24'h000000, q.cnt[cidx]};
        default: rd = {28'h0000000, q.ctl[cidx]};
      endcase
    end else begin
      case (paddr)
        iec_pkg::OFF_EDGE: rd = {24'h000000, q.edge_mode};
        iec_pkg::OFF_ROUTE: rd = {12'h000, q.miss, q.route};
        iec_pkg::OFF_PAT: rd = q.pat;
        iec_pkg::OFF_SEL: rd = {24'h000000, q.sel};
        iec_pkg::OFF_TRAP: rd = {24'h000000, q.tflag};
        iec_pkg::OFF_CFG: rd = {31'h00000000, q.jc};
        iec_pkg::OFF_STAT: rd = {18'h00000, q.vec, q.tlvl, q.st};
        default: hit = 1'b0;
      endcase
    end
    // One wait state, so pready and prdata both come from flip-flops
    if (psel && penable && !q.pready) begin
      n.pready = 1'b1;
      n.prdata = rd;
      n.pslverr = !hit;
    end

    // Writes land on the edge that completes the access
    if (psel && penable && q.pready && pwrite && hit) begin
      if (node_hit) begin
        n.prio[nidx] = pwdata[3:0];
        n.en[nidx] = pwdata[iec_pkg::NODE_EN_BIT];
        n.flag[nidx] = pwdata[iec_pkg::NODE_FLAG_BIT];
        n.xfer[nidx] = pwdata[iec_pkg::NODE_XFER_BIT];
        n.chan[nidx] = pwdata[iec_pkg::NODE_CH_LSB +: 3];
      end else if (ch_hit) begin
        case (paddr[3:2])
          2'h0: n.src[cidx] = pwdata[15:0];
          2'h1: n.dst[cidx] = pwdata[15:0];
          2'h2: n.cnt[cidx] = pwdata[7:0];
          default: n.ctl[cidx] = pwdata[3:0];
        endcase
      end else begin
        case (paddr)
          iec_pkg::OFF_EDGE: n.edge_mode = pwdata[7:0];
          iec_pkg::OFF_ROUTE: begin
            n.route = pwdata[15:0];
            n.miss = pwdata[19:16];
          end
          iec_pkg::OFF_PAT: n.pat = pwdata;
          iec_pkg::OFF_SEL: n.sel = pwdata[7:0];
          iec_pkg::OFF_TRAP: n.tflag = q.tflag & ~pwdata[7:0];
          iec_pkg::OFF_CFG: n.jc = pwdata[0];
          default: n.jc = q.jc;
        endcase
      end
    end

    // Shared nodes pick their source from the select bits
    for (int s = 0; s < 8; s++) begin
      if (q.sel[s]) begin
        req[iec_pkg::SHARED_BASE + s] = alt_req[s];
      end
    end
    // Edge detection, routing matrix and pattern gating
    for (int i = 0; i < 4; i++) begin
      ev[i] = edge_hit(q.edge_mode[2*i +: 2], ext_in[i],
                       q.ext_prev[i]);
    end
    for (int o = 0; o < 4; o++) begin
      logic match;
      match = ((ext_in ^ q.pat[8*o +: 4]) & q.pat[8*o+4 +: 4]) == 4'h0;
      gate[o] = (|(ev & q.route[4*o +: 4]))
                && (q.miss[o] ? !match : match);
    end
    req[3:0] = req[3:0] | gate;
    n.ext_prev = ext_in;

    // Hardware traps, system requests from the service pins, software traps
    tev[5:0] = trap_in;
    tev[iec_pkg::TRAP_SR0] = ext_service_pins[0]
                             && !q.esr_prev[0];
    tev[iec_pkg::TRAP_SR1] = (ext_service_pins[1] && !q.esr_prev[1])
                             || (ext_service_pins[2] && !q.esr_prev[2]);
    n.esr_prev = ext_service_pins;
    if (swtrap_valid) begin
      if (swtrap_num < 8'd8) begin
        tev[swtrap_num[2:0]] = 1'b1;
      end else begin
        snum = swtrap_num - 8'd8;
        if (snum < 8'd96) begin
          req[snum[6:0]] = 1'b1;
        end
      end
    end

    // Highest priority value wins; lowest index breaks a tie
    for (int k = 0; k < iec_pkg::NODES; k++) begin
      if (q.flag[k] && q.en[k] && q.prio[k] > best_prio) begin
        best_found = 1'b1;
        best_prio = q.prio[k];
        bidx = 7'(k);
      end
    end
    for (int t = 0; t < iec_pkg::TRAPS; t++) begin
      if (q.tpend[t]) begin
        tp_found = 1'b1;
        tidx = 3'(t);
      end
    end

    if (cpu_ret) begin
      n.tlvl = iec_pkg::RST_ZERO4;
    end
    // Service sequencing
    case (q.st)
      iec_pkg::ST_IDLE: begin
        if (tp_found && ({1'b0, tidx} + 4'd1 > q.tlvl)) begin
          take_trap = 1'b1;
          take_svc = 1'b1;
          n.tpend[tidx] = 1'b0;
          n.tlvl = {1'b0, tidx} + 4'd1;
          n.vec = iec_pkg::TRAP_VEC_BASE + {5'h00, tidx};
          n.is_trap = 1'b1;
          n.lat = q.jc ? iec_pkg::LAT_JC : iec_pkg::LAT_NOJC;
          n.st = iec_pkg::ST_WAIT;
        end else if (q.tlvl == 4'h0 && best_found) begin
          n.flag[bidx] = 1'b0;
          ch = q.chan[bidx];
          xch = ch;
          if (q.xfer[bidx] && (q.cnt[ch] != 8'h00
              || q.ctl[ch][iec_pkg::CTL_CONT])) begin
            // Transfer: one pulse, no vector, no wait
            take_xfer = 1'b1;
            step = q.ctl[ch][iec_pkg::CTL_WORD] ? 16'h0002 : 16'h0001;
            n.xv = 1'b1;
            n.xs = q.src[ch];
            n.xd = q.dst[ch];
            n.xw = q.ctl[ch][iec_pkg::CTL_WORD];
            if (q.ctl[ch][iec_pkg::CTL_INC_SRC]) begin
              n.src[ch] = q.src[ch] + step;
            end
            if (q.ctl[ch][iec_pkg::CTL_INC_DST]) begin
              n.dst[ch] = q.dst[ch] + step;
            end
            if (!q.ctl[ch][iec_pkg::CTL_CONT]) begin
              n.cnt[ch] = q.cnt[ch] - 8'd1;
              if (q.cnt[ch] == 8'd1) begin
                n.flag[bidx] = 1'b1;
              end
            end
          end else begin
            // An exhausted counter falls back to a vectored service
            take_svc = 1'b1;
            n.vec = iec_pkg::NODE_VEC_BASE + {1'b0, bidx};
            n.is_trap = 1'b0;
            n.lat = q.jc ? iec_pkg::LAT_JC : iec_pkg::LAT_NOJC;
            n.st = iec_pkg::ST_WAIT;
          end
        end
      end
      iec_pkg::ST_WAIT: begin
        n.lat = q.lat - 4'd1;
        if (q.lat == 4'd1) begin
          n.irq_req = 1'b1;
          n.st = iec_pkg::ST_SVC;
        end
      end
      iec_pkg::ST_SVC: begin
        if (cpu_ack) begin
          n.irq_req = 1'b0;
          n.st = iec_pkg::ST_IDLE;
        end
      end
      default: n.st = iec_pkg::ST_IDLE;
    endcase

    // Hardware and pin sets come last so a set beats a clear
    n.flag = n.flag | req;
    n.tpend = n.tpend | tev;
    n.tflag = n.tflag | tev;
  end

  // State register; everything clears on reset
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq_req = q.irq_req;
  assign irq_vector = q.vec;
  assign irq_is_trap = q.is_trap;
  assign xfer_valid = q.xv;
  assign xfer_src = q.xs;
  assign xfer_dst = q.xd;
  assign xfer_word = q.xw;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // The request register is seen high one edge after the count ends
  sequence s_quiet7;
    !q.irq_req [*8] ##1 q.irq_req;
  endsequence
  sequence s_quiet11;
    ##11 !q.irq_req ##1 q.irq_req;
  endsequence

  AST_LAT_JC: assert property (take_svc && q.jc |-> s_quiet7)
    else $error("service request not raised 7 clocks after accept");
  AST_LAT_NOJC: assert property (take_svc && !q.jc |-> s_quiet11)
    else $error("service request not raised 11 clocks after accept");
  AST_XFER_ONE: assert property (take_xfer |=> q.xv ##1 !q.xv)
    else $error("transfer pulse not exactly one cycle");
  AST_CNT_DEC: assert property (take_xfer && !q.ctl[xch][3]
    |=> q.cnt[$past(xch)] == $past(q.cnt[xch]) - 8'd1)
    else $error("transfer counter not decremented");
  AST_CNT_HOLD: assert property (take_xfer && q.ctl[xch][3]
    |=> q.cnt[$past(xch)] == $past(q.cnt[xch]))
    else $error("counter changed in continuous mode");
  AST_SRC_STEP: assert property (take_xfer && q.ctl[xch][0]
    |=> q.src[$past(xch)] == $past(q.src[xch])
        + ($past(q.ctl[xch][2]) ? 16'h0002 : 16'h0001))
    else $error("source pointer not stepped");
  AST_ZERO_IRQ: assert property (take_xfer && !q.ctl[xch][3]
    && q.cnt[xch] == 8'd1 |=> q.flag[$past(bidx)])
    else $error("no request after counter reached zero");
  AST_TRAP_FLAG: assert property ($rose(trap_in[2]) |=> q.tflag[2])
    else $error("trap flag not set");
  AST_NO_PREEMPT: assert property (q.tlvl != 4'h0
    |-> !take_xfer && !(take_svc && !take_trap))
    else $error("node service started during a trap");
  AST_GRANT_CLR: assert property (take_svc && !take_trap
    && !src_req[bidx] |=> !q.flag[$past(bidx)])
    else $error("granted node flag not cleared");
endmodule

// ==== dv/cpu_core_model.sv ====
// CPU-side partner: takes vectored services and ends trap services.
// Assumes the controller holds irq_req until it samples cpu_ack.
module cpu_core_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic irq_req,
  input wire logic irq_is_trap,
  input wire logic [7:0] ack_gap,
  output logic cpu_ack,
  output logic cpu_ret
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_n;
  int ret_n;
  // Ack after ack_gap cycles; a slow CPU stresses the hold of irq_req
  always @(posedge clk_sys) begin
    if (!nrst) begin
      cpu_ack <= 1'b0;
      cpu_ret <= 1'b0;
      wait_n <= 0;
      ret_n <= 0;
    end else begin
      cpu_ack <= irq_req && !cpu_ack && (wait_n >= ack_gap);
      cpu_ret <= (ret_n == 1);
      if (irq_req && !cpu_ack) begin
        wait_n <= (wait_n >= ack_gap) ? 0 : wait_n + 1;
      end
      // Trap handlers run long so later requests meet a busy trap
      if (irq_req && !cpu_ack && wait_n >= ack_gap && irq_is_trap) begin
        ret_n <= 40;
      end else if (ret_n != 0) begin
        ret_n <= ret_n - 1;
      end
    end
  end
endmodule

// ==== dv/irq_event_ctrl_tb.sv ====
// Self-checking bench for the interrupt and event controller.
// Assumes the CPU model acknowledges services and ends traps.
module irq_event_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [95:0] src_req;
  logic [7:0] alt_req, swtrap_num, irq_vector, ack_gap;
  logic [3:0] ext_in;
  logic [5:0] trap_in;
  logic [2:0] ext_service_pins;
  logic swtrap_valid, cpu_ack, cpu_ret, irq_req, irq_is_trap;
  logic xfer_valid, xfer_word, xw;
  logic [15:0] xfer_src, xfer_dst, xs, xd;
  int checks, fail_count, n;
  int xn = 0;
  irq_event_ctrl uut (.clk_sys, .nrst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .src_req, .alt_req, .ext_in,
    .trap_in, .ext_service_pins, .swtrap_valid, .swtrap_num, .cpu_ack,
    .cpu_ret, .irq_req, .irq_vector, .irq_is_trap, .xfer_valid, .xfer_src,
    .xfer_dst, .xfer_word);
  cpu_core_model cpu (.clk_sys, .nrst, .irq_req, .irq_is_trap, .ack_gap,
    .cpu_ack, .cpu_ret);
  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Record every transfer pulse in the cycle it stands
  always @(posedge clk_sys) begin
    if (xfer_valid === 1'b1) begin
      xs <= xfer_src;
      xd <= xfer_dst;
      xw <= xfer_word;
      xn <= xn + 1;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rdv);
  endtask
  task automatic pulse(input logic [95:0] m);
    src_req <= m;
    @(posedge clk_sys);
    src_req <= 96'h0;
    repeat (4) @(posedge clk_sys);
  endtask
  // Waits for a service, returns its delay in edges
  task automatic wait_irq(input logic [7:0] v, input logic t,
    output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (irq_req !== 1'b1 && c < 300);
    chk("irq_req", 32'h1, {31'h0, irq_req});
    chk("irq_vector", {24'h0, v}, {24'h0, irq_vector});
    chk("irq_is_trap", {31'h0, t}, {31'h0, irq_is_trap});
    for (int k = 0; k < 20 && irq_req === 1'b1; k++) @(posedge clk_sys);
  endtask
  task automatic xfer_case(input logic [11:0] c, input int ni,
    input logic [31:0] ctl, cnt, input int p);
    int ss, ds, b;
    ss = ctl[0] ? (ctl[2] ? 2 : 1) : 0;
    ds = ctl[1] ? (ctl[2] ? 2 : 1) : 0;
    wr(c, 32'h1000);
    wr(c + 12'h4, 32'h2000);
    wr(c + 12'h8, cnt);
    wr(c + 12'hc, ctl);
    wr(12'(ni * 4), 32'h142 | (32'(c[6:4]) << 9));
    for (int k = 0; k < p; k++) begin
      b = xn;
      pulse(96'h1 << ni);
      chk("xfer_count", b + 1, xn);
      chk("xfer_src", 32'h1000 + k * ss, {16'h0, xs});
      chk("xfer_dst", 32'h2000 + k * ds, {16'h0, xd});
      chk("xfer_word", {31'h0, ctl[2]}, {31'h0, xw});
    end
    if (!ctl[3] && cnt == p) wait_irq(8'(8 + ni), 1'b0, b);
    rd(c, 32'h1000 + p * ss);
    rd(c + 12'h4, 32'h2000 + p * ds);
    rd(c + 12'h8, ctl[3] ? cnt : cnt - p);
  endtask
  task automatic edge_try(input logic [3:0] v, input logic f);
    wr(12'h000, 32'h0);
    ext_in <= v;
    repeat (4) @(posedge clk_sys);
    rd(12'h000, {24'h0, f, 7'h0});
  endtask
  task automatic summarize;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Cut a hang short well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    summarize;
  end
  // Main sequence
  initial begin
    {nrst, psel, penable, pwrite, swtrap_valid} = 5'h0;
    {paddr, pwdata, src_req, alt_req} = 148'h0;
    {ext_in, trap_in, ext_service_pins, swtrap_num, ack_gap} = 29'h0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(12'h014, 32'h0);
    rd(12'h180, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    for (int j = 0; j < 2; j++) begin
      ack_gap <= j ? 8'h3 : 8'h0;
      wr(iec_pkg::OFF_CFG, j);
      wr(12'h014, 32'hc3);
      wait_irq(8'h0d, 1'b0, n);
      chk("latency", (j ? iec_pkg::LAT_JC : iec_pkg::LAT_NOJC) + 1, n);
      rd(12'h014, 32'h43);
    end
    wr(12'h024, 32'h47);
    pulse((96'h1 << 5) | (96'h1 << 9));
    wait_irq(8'h11, 1'b0, n);
    wait_irq(8'h0d, 1'b0, n);
    trap_in <= 6'h04;
    @(posedge clk_sys);
    trap_in <= 6'h00;
    wait_irq(8'h02, 1'b1, n);
    trap_in <= 6'h10;
    @(posedge clk_sys);
    trap_in <= 6'h00;
    wait_irq(8'h04, 1'b1, n);
    pulse(96'h1 << 5);
    repeat (15) @(posedge clk_sys);
    chk("irq_req", 32'h0, {31'h0, irq_req});
    wait_irq(8'h0d, 1'b0, n);
    ext_service_pins <= 3'h1;
    wait_irq(8'h06, 1'b1, n);
    ext_service_pins <= 3'h5;
    wait_irq(8'h07, 1'b1, n);
    ext_service_pins <= 3'h0;
    rd(iec_pkg::OFF_TRAP, 32'hd4);
    wr(iec_pkg::OFF_TRAP, 32'hd4);
    rd(iec_pkg::OFF_TRAP, 32'h0);
    for (int t = 3; t < 16; t += 10) begin
      swtrap_num <= 8'(t);
      swtrap_valid <= 1'b1;
      @(posedge clk_sys);
      swtrap_valid <= 1'b0;
      wait_irq(8'(t), t < 8, n);
    end
    xfer_case(12'h220, 10, 32'h7, 32'h2, 2);
    xfer_case(12'h210, 11, 32'ha, 32'h5, 1);
    wr(iec_pkg::OFF_ROUTE, 32'h1);
    for (int m = 1; m < 4; m++) begin
      wr(iec_pkg::OFF_EDGE, m);
      edge_try(4'h1, m[0]);
      edge_try(4'h0, m[1]);
    end
    wr(iec_pkg::OFF_EDGE, 32'h1);
    wr(iec_pkg::OFF_PAT, 32'h22);
    edge_try(4'h1, 1'b0);
    edge_try(4'h0, 1'b0);
    wr(iec_pkg::OFF_ROUTE, 32'h10001);
    edge_try(4'h1, 1'b1);
    wr(iec_pkg::OFF_SEL, 32'h1);
    wr(12'h160, 32'h0);
    alt_req <= 8'h01;
    pulse(96'h0);
    alt_req <= 8'h00;
    rd(12'h160, 32'h80);
    wr(12'h160, 32'h0);
    pulse(96'h1 << 88);
    rd(12'h160, 32'h0);
    summarize;
  end
endmodule
